// File: shared/reg_bank_pkg.sv
package reg_bank_pkg;

  localparam int NUM_PORTS = 7;
  localparam int PORT_A    = 0;
  localparam int PORT_B    = 1;
  localparam int PORT_C    = 2;
  localparam int PORT_D    = 3;
  localparam int PORT_E    = 4;
  localparam int PORT_F    = 5;
  localparam int PORT_G    = 6;

  // Offsets inside the 256-byte register window
  localparam logic [7:0] OFS_IN_A    = 8'h00;
  localparam logic [7:0] OFS_IN_B    = 8'h01;
  localparam logic [7:0] OFS_IN_C    = 8'h10;
  localparam logic [7:0] OFS_IN_D    = 8'h11;
  localparam logic [7:0] OFS_IN_E    = 8'h30;
  localparam logic [7:0] OFS_IN_F    = 8'h40;
  localparam logic [7:0] OFS_IN_G    = 8'h41;
  localparam logic [7:0] OFS_CTL_E   = 8'h32;
  localparam logic [7:0] OFS_CTL_F   = 8'h42;
  localparam logic [7:0] OFS_CTL_G   = 8'h43;
  localparam logic [7:0] OFS_OUT_A   = 8'h04;
  localparam logic [7:0] OFS_OUT_B   = 8'h05;
  localparam logic [7:0] OFS_OUT_C   = 8'h12;
  localparam logic [7:0] OFS_OUT_D   = 8'h13;
  localparam logic [7:0] OFS_OUT_E   = 8'h34;
  localparam logic [7:0] OFS_OUT_F   = 8'h44;
  localparam logic [7:0] OFS_OUT_G   = 8'h45;
  localparam logic [7:0] OFS_DIR_A   = 8'h06;
  localparam logic [7:0] OFS_DIR_B   = 8'h07;
  localparam logic [7:0] OFS_DIR_C   = 8'h14;
  localparam logic [7:0] OFS_DIR_D   = 8'h15;
  localparam logic [7:0] OFS_DIR_E   = 8'h36;
  localparam logic [7:0] OFS_DIR_F   = 8'h46;
  localparam logic [7:0] OFS_DIR_G   = 8'h47;
  localparam logic [7:0] OFS_DRV_A   = 8'h08;
  localparam logic [7:0] OFS_DRV_B   = 8'h09;
  localparam logic [7:0] OFS_DRV_C   = 8'h18;
  localparam logic [7:0] OFS_DRV_D   = 8'h19;
  localparam logic [7:0] OFS_DRV_E   = 8'h38;
  localparam logic [7:0] OFS_DRV_F   = 8'h48;
  localparam logic [7:0] OFS_DRV_G   = 8'h49;
  localparam logic [7:0] OFS_IMC_A   = 8'h0a;
  localparam logic [7:0] OFS_IMC_B   = 8'h0b;
  localparam logic [7:0] OFS_IMC_C   = 8'h1a;
  localparam logic [7:0] OFS_OE_A    = 8'h0c;
  localparam logic [7:0] OFS_OE_B    = 8'h0d;
  localparam logic [7:0] OFS_OE_C    = 8'h1c;
  localparam logic [7:0] OFS_OE_F    = 8'h4c;
  localparam logic [7:0] OFS_CELL_A  = 8'h20;
  localparam logic [7:0] OFS_CELL_B  = 8'h21;
  localparam logic [7:0] OFS_MASK_A  = 8'h22;
  localparam logic [7:0] OFS_MASK_B  = 8'h23;
  localparam logic [7:0] OFS_PROT_P  = 8'hc0;
  localparam logic [7:0] OFS_PROT_S  = 8'hc2;
  localparam logic [7:0] OFS_TEST_EN = 8'hc7;
  localparam logic [7:0] OFS_PWR0    = 8'hb0;
  localparam logic [7:0] OFS_PAGE    = 8'he0;

  // Field positions
  localparam int SEC_BIT_POS      = 7;
  localparam int SEC_PROT_MSB     = 3;
  localparam int TEST_ON_POS      = 0;
  localparam int APD_POS          = 1;
  localparam int FAST_OFF_POS     = 3;
  localparam int ARRAY_CLK_POS    = 4;
  localparam int CELL_CLK_POS     = 5;
  localparam logic [7:0] PWR0_WMASK = 8'h3a;

  // Reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_PAGE     = 8'h00;
  localparam logic [7:0] RST_TEST_EN  = 8'h00;

endpackage

// File: logic/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_in,  // System clock
  input  wire logic             nrst_in,     // Async reset, active low
  input  wire logic [WIDTH-1:0] async_in,    // Unsynchronised level
  output logic      [WIDTH-1:0] sync_out     // Synchronised level
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// File: logic/power_ctl_reg.sv
`timescale 1ns/1ps
module power_ctl_reg
  import reg_bank_pkg::*;
(
  input  wire logic       clk_sys_in,   // System clock
  input  wire logic       npor_in,      // Power-up reset only, active low
  input  wire logic       wr_in,        // Write strobe for this register
  input  wire logic [7:0] wdata_in,     // Write data
  output logic      [7:0] value_out     // Register contents
);
  // Only power-up clears it; the ordinary reset pin is not wired here
  always_ff @(posedge clk_sys_in or negedge npor_in) begin
    if (!npor_in) begin
      value_out <= RST_BYTE;
    end else if (wr_in) begin
      value_out <= wdata_in & PWR0_WMASK;
    end
  end
endmodule

// File: logic/config_register_bank.sv
`timescale 1ns/1ps
module config_register_bank
  import reg_bank_pkg::*;
(
  input  wire logic        clk_sys_in,                // 40 MHz system clock
  input  wire logic        nrst_in,                   // Reset pin, active low
  input  wire logic        npor_in,                   // Power-up reset, active low
  input  wire logic        register_window_select_in, // Window select from decoder
  input  wire logic [7:0]  addr_in,                   // Byte offset in window
  input  wire logic        rd_in,                     // Read strobe
  input  wire logic        wr_in,                     // Write strobe
  input  wire logic [7:0]  wdata_in,                  // Write data
  output logic      [7:0]  rdata_out,                 // Read data, registered
  input  wire logic [55:0] port_pin_in,               // Pin levels, 8 per port A..G
  output logic      [55:0] port_pin_out,              // Pin output data
  output logic      [55:0] port_pin_oe_out,           // Pin output enable
  output logic      [55:0] port_slew_fast_out,        // High slew select per pin
  input  wire logic [55:0] latched_addr_in,           // Latched address per pin
  input  wire logic [55:0] array_out_in,              // Logic-array output per pin
  input  wire logic [55:0] array_oe_in,               // Logic-array enable per pin
  input  wire logic [23:0] input_cell_bits_in,        // Input cells, ports A..C
  input  wire logic [7:0]  primary_protect_in,        // Primary sector protection
  input  wire logic [3:0]  secondary_protect_in,      // Secondary sector protection
  input  wire logic        security_set_in,           // Security bit state
  output logic      [7:0]  output_cell_bank_a_bits_out, // Cell bank A outputs
  output logic      [7:0]  output_cell_bank_b_bits_out, // Cell bank B outputs
  output logic             test_port_on_out,          // Serial test port enable
  output logic      [7:0]  page_bits_out,             // Page inputs to logic array
  output logic             auto_power_down_on_out,    // Automatic power-down enable
  output logic             array_fast_mode_off_out,   // Fast array mode off
  output logic             array_clock_gate_out,      // Clock cut from AND array
  output logic             cell_clock_gate_out        // Clock cut from cells
);
  import reg_bank_pkg::*;

  logic [7:0]  pin_sync [NUM_PORTS];
  logic [55:0] pin_sync_flat;
  logic [7:0]  out_latch_reg [NUM_PORTS];
  logic [7:0]  dir_reg       [NUM_PORTS];
  logic [7:0]  drive_reg     [NUM_PORTS];
  logic [7:0]  addr_sel_reg  [NUM_PORTS];
  logic [7:0]  oe_now        [NUM_PORTS];
  logic [7:0]  cell_a_reg;
  logic [7:0]  cell_b_reg;
  logic [7:0]  mask_a_reg;
  logic [7:0]  mask_b_reg;
  logic [7:0]  page_reg;
  logic        test_on_reg;
  logic [7:0]  pwr0_value;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata_next;

  // Window select qualifies strobes; offsets are full 8-bit
  assign wr_stb = register_window_select_in & wr_in;
  assign rd_stb = register_window_select_in & rd_in;

  sync_2ff #(
    .WIDTH (56)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (port_pin_in),
    .sync_out   (pin_sync_flat)
  );

  power_ctl_reg u_pwr0 (
    .clk_sys_in (clk_sys_in),
    .npor_in    (npor_in),
    .wr_in      (wr_stb && addr_in == OFS_PWR0),
    .wdata_in   (wdata_in),
    .value_out  (pwr0_value)
  );

  // Per-port offsets; 8'hff marks a register the port lacks
  function automatic logic [7:0] ofs_out(input int p);
    case (p)
      PORT_A:  ofs_out = OFS_OUT_A;
      PORT_B:  ofs_out = OFS_OUT_B;
      PORT_C:  ofs_out = OFS_OUT_C;
      PORT_D:  ofs_out = OFS_OUT_D;
      PORT_E:  ofs_out = OFS_OUT_E;
      PORT_F:  ofs_out = OFS_OUT_F;
      default: ofs_out = OFS_OUT_G;
    endcase
  endfunction

  function automatic logic [7:0] ofs_dir(input int p);
    case (p)
      PORT_A:  ofs_dir = OFS_DIR_A;
      PORT_B:  ofs_dir = OFS_DIR_B;
      PORT_C:  ofs_dir = OFS_DIR_C;
      PORT_D:  ofs_dir = OFS_DIR_D;
      PORT_E:  ofs_dir = OFS_DIR_E;
      PORT_F:  ofs_dir = OFS_DIR_F;
      default: ofs_dir = OFS_DIR_G;
    endcase
  endfunction

  function automatic logic [7:0] ofs_drv(input int p);
    case (p)
      PORT_A:  ofs_drv = OFS_DRV_A;
      PORT_B:  ofs_drv = OFS_DRV_B;
      PORT_C:  ofs_drv = OFS_DRV_C;
      PORT_D:  ofs_drv = OFS_DRV_D;
      PORT_E:  ofs_drv = OFS_DRV_E;
      PORT_F:  ofs_drv = OFS_DRV_F;
      default: ofs_drv = OFS_DRV_G;
    endcase
  endfunction

  function automatic logic [7:0] ofs_in(input int p);
    case (p)
      PORT_A:  ofs_in = OFS_IN_A;
      PORT_B:  ofs_in = OFS_IN_B;
      PORT_C:  ofs_in = OFS_IN_C;
      PORT_D:  ofs_in = OFS_IN_D;
      PORT_E:  ofs_in = OFS_IN_E;
      PORT_F:  ofs_in = OFS_IN_F;
      default: ofs_in = OFS_IN_G;
    endcase
  endfunction

  function automatic logic [7:0] ofs_ctl(input int p);
    case (p)
      PORT_E:  ofs_ctl = OFS_CTL_E;
      PORT_F:  ofs_ctl = OFS_CTL_F;
      PORT_G:  ofs_ctl = OFS_CTL_G;
      default: ofs_ctl = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] ofs_oe(input int p);
    case (p)
      PORT_A:  ofs_oe = OFS_OE_A;
      PORT_B:  ofs_oe = OFS_OE_B;
      PORT_C:  ofs_oe = OFS_OE_C;
      PORT_F:  ofs_oe = OFS_OE_F;
      default: ofs_oe = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] ofs_imc(input int p);
    case (p)
      PORT_A:  ofs_imc = OFS_IMC_A;
      PORT_B:  ofs_imc = OFS_IMC_B;
      PORT_C:  ofs_imc = OFS_IMC_C;
      default: ofs_imc = 8'hff;
    endcase
  endfunction

  // Slew-capable ports; the rest use the drive bit for open drain
  function automatic logic is_slew_port(input int p);
    is_slew_port = (p == PORT_C) || (p == PORT_F);
  endfunction

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign pin_sync[p] = pin_sync_flat[p*8 +: 8];

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
        out_latch_reg[p] <= RST_BYTE;
        dir_reg[p]       <= RST_BYTE;
        drive_reg[p]     <= RST_BYTE;
        addr_sel_reg[p]  <= RST_BYTE;
      end else if (wr_stb) begin
        if (addr_in == ofs_out(p))
          out_latch_reg[p] <= wdata_in;
        if (addr_in == ofs_dir(p))
          dir_reg[p] <= wdata_in;
        if (addr_in == ofs_drv(p))
          drive_reg[p] <= wdata_in;
        if (ofs_ctl(p) != 8'hff && addr_in == ofs_ctl(p))
          addr_sel_reg[p] <= wdata_in;
      end
    end

    // Per-pin source: address-out, host output, or logic array
    for (genvar b = 0; b < 8; b++) begin : g_bit
      logic drv_data;
      logic drv_en;
      always_comb begin
        if (addr_sel_reg[p][b]) begin
          drv_data = latched_addr_in[p*8+b];
          drv_en   = 1'b1;
        end else if (dir_reg[p][b]) begin
          drv_data = out_latch_reg[p][b];
          drv_en   = 1'b1;
        end else begin
          drv_data = array_out_in[p*8+b];
          drv_en   = array_oe_in[p*8+b];
        end
        // Open drain only pulls low; a one releases the pin
        if (!is_slew_port(p) && drive_reg[p][b])
          oe_now[p][b] = drv_en & ~drv_data;
        else
          oe_now[p][b] = drv_en;
      end

      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          port_pin_out[p*8+b]       <= 1'b0;
          port_pin_oe_out[p*8+b]    <= 1'b0;
          port_slew_fast_out[p*8+b] <= 1'b0;
        end else begin
          port_pin_out[p*8+b]       <= drv_data;
          port_pin_oe_out[p*8+b]    <= oe_now[p][b];
          port_slew_fast_out[p*8+b] <= is_slew_port(p) & drive_reg[p][b];
        end
      end
    end
  end

  // Output cells; mask bit 1 keeps that flip-flop
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cell_a_reg <= RST_BYTE;
      cell_b_reg <= RST_BYTE;
      mask_a_reg <= RST_BYTE;
      mask_b_reg <= RST_BYTE;
    end else if (wr_stb) begin
      if (addr_in == OFS_CELL_A)
        cell_a_reg <= (wdata_in & ~mask_a_reg) | (cell_a_reg & mask_a_reg);
      if (addr_in == OFS_CELL_B)
        cell_b_reg <= (wdata_in & ~mask_b_reg) | (cell_b_reg & mask_b_reg);
      if (addr_in == OFS_MASK_A)
        mask_a_reg <= wdata_in;
      if (addr_in == OFS_MASK_B)
        mask_b_reg <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      page_reg    <= RST_PAGE;
      test_on_reg <= RST_TEST_EN[TEST_ON_POS];
    end else if (wr_stb) begin
      if (addr_in == OFS_PAGE)
        page_reg <= wdata_in;
      if (addr_in == OFS_TEST_EN)
        test_on_reg <= wdata_in[TEST_ON_POS];
    end
  end

  // Read mux; unmapped offsets and unused bits return zero
  always_comb begin
    rdata_next = RST_BYTE;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (addr_in == ofs_in(p))
        rdata_next = pin_sync[p];
      if (addr_in == ofs_out(p))
        rdata_next = out_latch_reg[p];
      if (addr_in == ofs_dir(p))
        rdata_next = dir_reg[p];
      if (addr_in == ofs_drv(p))
        rdata_next = drive_reg[p];
      if (ofs_ctl(p) != 8'hff && addr_in == ofs_ctl(p))
        rdata_next = addr_sel_reg[p];
      if (ofs_oe(p) != 8'hff && addr_in == ofs_oe(p))
        rdata_next = oe_now[p];
      if (ofs_imc(p) != 8'hff && addr_in == ofs_imc(p))
        rdata_next = input_cell_bits_in[p*8 +: 8];
    end
    case (addr_in)
      OFS_CELL_A:  rdata_next = cell_a_reg;
      OFS_CELL_B:  rdata_next = cell_b_reg;
      OFS_MASK_A:  rdata_next = mask_a_reg;
      OFS_MASK_B:  rdata_next = mask_b_reg;
      OFS_PROT_P:  rdata_next = primary_protect_in;
      OFS_PROT_S:  rdata_next = {security_set_in, 3'b000, secondary_protect_in};
      OFS_TEST_EN: rdata_next = {7'h00, test_on_reg};
      OFS_PWR0:    rdata_next = pwr0_value;
      OFS_PAGE:    rdata_next = page_reg;
      default:     rdata_next = rdata_next;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in)
      rdata_out <= RST_BYTE;
    else if (rd_stb)
      rdata_out <= rdata_next;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      output_cell_bank_a_bits_out <= RST_BYTE;
      output_cell_bank_b_bits_out <= RST_BYTE;
      test_port_on_out            <= 1'b0;
      page_bits_out               <= RST_PAGE;
    end else begin
      output_cell_bank_a_bits_out <= cell_a_reg;
      output_cell_bank_b_bits_out <= cell_b_reg;
      test_port_on_out            <= test_on_reg;
      page_bits_out               <= page_reg;
    end
  end

  // Power bits follow the power-up-only register, not the reset pin
  always_ff @(posedge clk_sys_in or negedge npor_in) begin
    if (!npor_in) begin
      auto_power_down_on_out  <= 1'b0;
      array_fast_mode_off_out <= 1'b0;
      array_clock_gate_out    <= 1'b0;
      cell_clock_gate_out     <= 1'b0;
    end else begin
      auto_power_down_on_out  <= pwr0_value[APD_POS];
      array_fast_mode_off_out <= pwr0_value[FAST_OFF_POS];
      array_clock_gate_out    <= pwr0_value[ARRAY_CLK_POS];
      cell_clock_gate_out     <= pwr0_value[CELL_CLK_POS];
    end
  end

endmodule

// File: tb/reg_bank_asserts.sv
`timescale 1ns/1ps
module reg_bank_asserts
  import reg_bank_pkg::*;
(
  input wire logic       clk_sys_in,                  // Clock
  input wire logic       nrst_in,                     // Reset pin
  input wire logic       npor_in,                     // Power-up reset
  input wire logic       register_window_select_in,   // Window select
  input wire logic [7:0] addr_in,                     // Offset
  input wire logic       rd_in,                       // Read strobe
  input wire logic       wr_in,                       // Write strobe
  input wire logic [7:0] wdata_in,                    // Write data
  input wire logic [7:0] rdata_out,                   // Read data
  input wire logic [7:0] primary_protect_in,          // Primary protection
  input wire logic [3:0] secondary_protect_in,        // Secondary protection
  input wire logic       security_set_in,             // Security bit
  input wire logic [7:0] output_cell_bank_a_bits_out, // Cell bank A
  input wire logic       test_port_on_out,            // Test port enable
  input wire logic [7:0] page_bits_out,               // Page outputs
  input wire logic       auto_power_down_on_out,      // Power bit 1
  input wire logic       array_fast_mode_off_out,     // Power bit 3
  input wire logic       array_clock_gate_out,        // Power bit 4
  input wire logic       cell_clock_gate_out          // Power bit 5
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] mask_a_reg;
  assign wr_ok = register_window_select_in && wr_in;
  assign rd_ok = register_window_select_in && rd_in && !wr_in;
  // Shadow of mask A, since the mask itself is not visible at the ports
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_a_reg <= 8'h00;
    end else if (wr_ok && addr_in == OFS_MASK_A) begin
      mask_a_reg <= wdata_in;
    end
  end
  rd_page_a: assert property (rd_ok && addr_in == OFS_PAGE |=> rdata_out == page_bits_out)
    else $error("page readback differs from page outputs");
  wr_page_a: assert property (wr_ok && addr_in == OFS_PAGE |=> ##1 page_bits_out == $past(wdata_in, 2))
    else $error("page outputs did not follow write");
  test_port_a: assert property (wr_ok && addr_in == OFS_TEST_EN |=> ##1 test_port_on_out == $past(wdata_in[0], 2))
    else $error("test port enable did not follow bit 0");
  power_wr_a: assert property (disable iff (!npor_in) nrst_in && wr_ok && addr_in == OFS_PWR0 |=> ##1
    {cell_clock_gate_out, array_clock_gate_out, array_fast_mode_off_out, auto_power_down_on_out} ==
    {$past(wdata_in[5:3], 2), $past(wdata_in[1], 2)})
    else $error("power outputs did not follow write");
  power_keep_a: assert property (disable iff (!npor_in) !nrst_in && !$past(nrst_in) |=>
    $stable(auto_power_down_on_out) && $stable(array_fast_mode_off_out) &&
    $stable(array_clock_gate_out) && $stable(cell_clock_gate_out))
    else $error("power outputs changed during reset pin pulse");
  cell_mask_a: assert property (wr_ok && addr_in == OFS_CELL_A |=> ##1 output_cell_bank_a_bits_out ==
    (($past(wdata_in, 2) & ~$past(mask_a_reg, 2)) | ($past(output_cell_bank_a_bits_out) & $past(mask_a_reg, 2))))
    else $error("cell bank A load ignores mask");
  unmapped_rd_a: assert property (rd_ok && addr_in == 8'hff |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!(register_window_select_in && rd_in) |=> $stable(rdata_out))
    else $error("read data changed without a read");
  prot_rd_a: assert property (rd_ok && addr_in == OFS_PROT_P |=> rdata_out == $past(primary_protect_in))
    else $error("primary protection readback wrong");
  boot_rd_a: assert property (rd_ok && addr_in == OFS_PROT_S |=>
    rdata_out == {$past(security_set_in), 3'h0, $past(secondary_protect_in)})
    else $error("secondary protection readback wrong");
  cover property (wr_ok && addr_in == OFS_CELL_A && mask_a_reg != 8'h00);
  cover property (disable iff (!npor_in) !nrst_in && auto_power_down_on_out);
  cover property (rd_ok && addr_in == 8'hff);
endmodule

bind config_register_bank reg_bank_asserts u_chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .npor_in(npor_in),
  .register_window_select_in(register_window_select_in), .addr_in(addr_in), .rd_in(rd_in),
  .wr_in(wr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .primary_protect_in(primary_protect_in),
  .secondary_protect_in(secondary_protect_in), .security_set_in(security_set_in),
  .output_cell_bank_a_bits_out(output_cell_bank_a_bits_out), .test_port_on_out(test_port_on_out),
  .page_bits_out(page_bits_out), .auto_power_down_on_out(auto_power_down_on_out),
  .array_fast_mode_off_out(array_fast_mode_off_out), .array_clock_gate_out(array_clock_gate_out),
  .cell_clock_gate_out(cell_clock_gate_out));

// File: tb/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk_sys_in, // Bus clock
  input  wire logic [7:0] rdata_in,   // Read data from bank
  output logic            sel_out,    // Window select
  output logic      [7:0] addr_out,   // Byte offset
  output logic            rd_out,     // Read strobe
  output logic            wr_out,     // Write strobe
  output logic      [7:0] wdata_out   // Write data
);
  initial begin
    sel_out = 1'b0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // One idle cycle between accesses; released lines carry inverted junk
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    wdata_out = d;
    sel_out = 1'b1;
    wr_out = 1'b1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    sel_out = 1'b0;
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    addr_out = a;
    sel_out = 1'b1;
    rd_out = 1'b1;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    d = rdata_in;
    sel_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
endmodule

// File: tb/peripheral_config_register_bank_tb.sv
`timescale 1ns/1ps
module peripheral_config_register_bank_tb;
  import reg_bank_pkg::*;
  typedef struct packed { logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp; } row_t;
  logic        clk_sys_in, nrst_in, npor_in, sel, rd, wr, sec;
  logic [7:0]  addr, wdata, rdata, prot_p, page, cell_a, cell_b, rv;
  logic [3:0]  prot_s;
  logic [23:0] cells;
  logic [55:0] pins, pin_out, pin_oe, slew, laddr, arr_out, arr_oe;
  logic        test_on, apd, fast_off, arr_gate, cell_gate;
  int          errors, n_tests, cycles;
  row_t rows [15] = '{
    '{OFS_PAGE,    8'ha5, 8'ha5},
    '{OFS_TEST_EN, 8'hff, 8'h01},
    '{OFS_PWR0,    8'hff, 8'h3a},
    '{OFS_DIR_B,   8'h3c, 8'h3c},
    '{OFS_OUT_D,   8'h5a, 8'h5a},
    '{OFS_CTL_G,   8'h0f, 8'h0f},
    '{OFS_DRV_G,   8'h81, 8'h81},
    '{OFS_MASK_B,  8'hf0, 8'hf0},
    '{OFS_CELL_B,  8'h66, 8'h06},
    '{OFS_PROT_P,  8'h55, 8'hc3},
    '{OFS_PROT_S,  8'h55, 8'h8a},
    '{OFS_IN_D,    8'h00, 8'h44},
    '{OFS_IMC_C,   8'h00, 8'hc3},
    '{OFS_OE_F,    8'h12, 8'h00},
    '{8'hff,       8'h77, 8'h00}};

  config_register_bank dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .npor_in(npor_in), .register_window_select_in(sel),
    .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata), .port_pin_in(pins),
    .port_pin_out(pin_out), .port_pin_oe_out(pin_oe), .port_slew_fast_out(slew), .latched_addr_in(laddr),
    .array_out_in(arr_out), .array_oe_in(arr_oe), .input_cell_bits_in(cells), .primary_protect_in(prot_p),
    .secondary_protect_in(prot_s), .security_set_in(sec), .output_cell_bank_a_bits_out(cell_a),
    .output_cell_bank_b_bits_out(cell_b), .test_port_on_out(test_on), .page_bits_out(page),
    .auto_power_down_on_out(apd), .array_fast_mode_off_out(fast_off), .array_clock_gate_out(arr_gate),
    .cell_clock_gate_out(cell_gate));
  host_bus_model host (
    .clk_sys_in(clk_sys_in), .rdata_in(rdata), .sel_out(sel), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wdata));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // Ceiling well above the roughly 125 cycles the sequence needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    nrst_in = 1'b0;
    npor_in = 1'b0;
    pins = 56'h77_66_55_44_33_22_11;
    laddr = 56'h00_00_c3_00_00_00_00;
    arr_out = '0;
    arr_oe = '0;
    cells = 24'hc3_b2_a1;
    prot_p = 8'hc3;
    prot_s = 4'ha;
    sec = 1'b1;
    repeat (16) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    npor_in = 1'b1;
    for (int i = 0; i < 15; i++) begin
      host.write_byte(rows[i].addr, rows[i].wdata);
      host.read_byte(rows[i].addr, rv);
      check("readback", rv, rows[i].exp);
    end
    check("page out", page, 8'ha5);
    check("cell b out", cell_b, 8'h06);
    check("test port", {7'h0, test_on}, 8'h01);
    check("power out", {4'h0, cell_gate, arr_gate, fast_off, apd}, 8'h0f);
    // Both levels of the security bit and of the test port enable
    sec = 1'b0;
    host.read_byte(OFS_PROT_S, rv);
    check("security clear", rv, 8'h0a);
    host.write_byte(OFS_TEST_EN, 8'h00);
    host.read_byte(OFS_TEST_EN, rv);
    check("test port off reg", rv, 8'h00);
    check("test port off", {7'h0, test_on}, 8'h00);
    // Reset pin pulse must spare power control 0
    nrst_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    check("page reset", page, 8'h00);
    check("power kept", {4'h0, cell_gate, arr_gate, fast_off, apd}, 8'h0f);
    host.read_byte(OFS_PWR0, rv);
    check("power reg kept", rv, 8'h3a);
    host.read_byte(OFS_DIR_B, rv);
    check("dir reset", rv, 8'h00);
    host.write_byte(OFS_MASK_A, 8'h0f);
    host.write_byte(OFS_CELL_A, 8'hff);
    host.read_byte(OFS_CELL_A, rv);
    check("cell a masked", rv, 8'hf0);
    check("cell a out", cell_a, 8'hf0);
    host.write_byte(OFS_MASK_A, 8'h00);
    host.write_byte(OFS_CELL_A, 8'h3c);
    host.read_byte(OFS_CELL_A, rv);
    check("cell a load", rv, 8'h3c);
    host.write_byte(OFS_DIR_A, 8'hff);
    host.write_byte(OFS_OUT_A, 8'ha5);
    @(negedge clk_sys_in);
    check("pin out a", pin_out[7:0], 8'ha5);
    check("pin oe a", pin_oe[7:0], 8'hff);
    host.read_byte(OFS_OE_A, rv);
    check("oe status a", rv, 8'hff);
    host.write_byte(OFS_DRV_A, 8'hff);
    host.write_byte(OFS_DRV_C, 8'h0f);
    host.write_byte(OFS_DIR_E, 8'hff);
    host.write_byte(OFS_CTL_E, 8'hf0);
    @(negedge clk_sys_in);
    check("open drain oe", pin_oe[7:0], 8'h5a);
    check("slew c", slew[23:16], 8'h0f);
    check("addr out e", pin_out[39:32], 8'hc0);
    pins[7:0] = 8'he7;
    repeat (3) @(negedge clk_sys_in);
    host.read_byte(OFS_IN_A, rv);
    check("pin in a", rv, 8'he7);
    npor_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    npor_in = 1'b1;
    check("power cleared", {4'h0, cell_gate, arr_gate, fast_off, apd}, 8'h00);
    finish_test();
  end
endmodule
